// *** shared/tcc_defs.vh ***
// constants for the two-channel capture/compare block
// assumes byte-wide register port with 3-bit address
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

// register offsets
`define TCC_OFS_CH0_CTRL   3'h0
`define TCC_OFS_CH0_HI     3'h1
`define TCC_OFS_CH0_LO     3'h2
`define TCC_OFS_CH1_CTRL   3'h3
`define TCC_OFS_CH1_HI     3'h4
`define TCC_OFS_CH1_LO     3'h5
`define TCC_OFS_TIMER_CTRL 3'h6
`define TCC_OFS_MOD_HI     3'h7

// control/status field positions
`define TCC_BIT_FLAG   7
`define TCC_BIT_IE     6
`define TCC_BIT_MSB    5
`define TCC_BIT_MSA    4
`define TCC_BIT_ELSB   3
`define TCC_BIT_ELSA   2
`define TCC_BIT_TOV    1
`define TCC_BIT_MAX    0

// timer control fields
`define TCC_BIT_HALT   7
`define TCC_BIT_CLEAR  6

// reset values
`define TCC_CTRL_RST   8'h00
`define TCC_TCTRL_RST  8'h80
`define TCC_MOD_RST    16'hffff

`endif

// *** hdl/tcc_channel.v ***
// one capture/compare channel: mode decode, flag, value, pin
// assumes count, wrap pulse and bus strobes on clk
`timescale 1ns/10ps
`include "tcc_defs.vh"

module tcc_channel
(
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // timer state
  input  wire [15:0] count,
  input  wire        wrap,
  input  wire        halt,
  input  wire        buffered,
  input  wire [15:0] buf_value,
  input  wire        enable,
  // control register fields
  input  wire [7:0]  ctrl,
  // flag handling
  input  wire        ctrl_rd,
  input  wire        ctrl_wr,
  input  wire        flag_wdata,
  // value access
  input  wire        hi_rd,
  input  wire        lo_rd,
  input  wire        hi_wr,
  input  wire        lo_wr,
  input  wire [7:0]  wdata,
  // pin
  input  wire        pin_in,
  output reg         pin_out,
  output reg         pin_oe,
  // status
  output reg         flag,
  output reg  [15:0] value
);

  // ***********************************
  // mode decode
  // ***********************************
  wire [1:0] els       = {ctrl[`TCC_BIT_ELSB], ctrl[`TCC_BIT_ELSA]};
  wire       connected = enable && (els != 2'b00);
  // compare selected even with edge field zero: flag only, pin left alone
  wire       cmp_sel   = enable && (ctrl[`TCC_BIT_MSA] || (buffered && connected));
  wire       cmp_mode  = connected && cmp_sel;
  wire       cap_mode  = connected && !cmp_sel;
  wire       tov       = ctrl[`TCC_BIT_TOV];

  reg        pin_d_reg;
  reg        armed_reg;
  reg        cap_block_reg;
  reg        cmp_block_reg;
  reg        max_reg;
  reg        pin_next;

  wire [15:0] target  = buffered ? buf_value : value;
  wire        rise    = pin_in && !pin_d_reg;
  wire        fall    = !pin_in && pin_d_reg;
  wire        edge_ok = (els == 2'b01) ? rise : (els == 2'b10) ? fall : (rise | fall);
  wire        capture = cap_mode && edge_ok && !cap_block_reg && !halt;
  wire        match   = cmp_sel && (count == target) && !cmp_block_reg;
  wire        event_s = capture || match;

  // ***********************************
  // output pin action
  // ***********************************
  always @*
  begin
    pin_next = pin_out;
    if (!connected)
      pin_next = !ctrl[`TCC_BIT_MSA];
    else if (cmp_mode)
    begin
      if (tov && wrap)
        pin_next = max_reg ? 1'b1 : !pin_out;
      else if (match && !(tov && max_reg))
      begin
        case (els)
          2'b01:   pin_next = !pin_out;
          2'b10:   pin_next = 1'b0;
          2'b11:   pin_next = 1'b1;
          default: pin_next = pin_out;
        endcase
      end
    end
  end

  always @(posedge clk)
  begin
    pin_d_reg <= pin_in;
    if (sys_rst)
    begin
      flag          <= 1'b0;
      armed_reg     <= 1'b0;
      cap_block_reg <= 1'b0;
      cmp_block_reg <= 1'b0;
      max_reg       <= 1'b0;
      pin_out       <= 1'b1;
      pin_oe        <= 1'b0;
    end
    else
    begin
      pin_out <= pin_next;
      pin_oe  <= cmp_mode;
      if (wrap)
        max_reg <= ctrl[`TCC_BIT_MAX];
      // flag: event wins over the clear write
      if (event_s)
      begin
        flag      <= 1'b1;
        armed_reg <= 1'b0;
      end
      else if (ctrl_wr && !flag_wdata && armed_reg)
      begin
        flag      <= 1'b0;
        armed_reg <= 1'b0;
      end
      else if (ctrl_rd && flag)
        armed_reg <= 1'b1;
      // byte latching
      if (lo_rd)
        cap_block_reg <= 1'b0;
      else if (hi_rd && cap_mode)
        cap_block_reg <= 1'b1;
      if (lo_wr)
        cmp_block_reg <= 1'b0;
      else if (hi_wr && cmp_sel)
        cmp_block_reg <= 1'b1;
    end
  end

  // value has no reset value
  always @(posedge clk)
  begin
    if (capture)
      value <= count;
    else
    begin
      if (hi_wr)
        value[15:8] <= wdata;
      if (lo_wr)
        value[7:0] <= wdata;
    end
  end

endmodule // tcc_channel

// *** hdl/tcc_top.v ***
// two-channel capture/compare/pwm unit with its timer counter
// assumes synchronous pins and a one-cycle register port
//
// Overview of operation
// - capture sets flag and loads count
// - compare match sets channel flag
// - flag clears by read-then-write zero only
// - writing one ignored; reset clears flag
// - irq while enable and flag set
// - buffered select only in channel zero
// - buffered mode disables channel one
// - unbuffered select picks compare or capture
// - edge field zero: select sets preset level
// - capture edge rising, falling or both
// - compare action none, toggle, low, high
// - edge field zero disconnects pin
// - toggle on wrap in compare mode
// - wrap action beats compare action
// - full duty forced from next period
// - high byte read blocks captures
// - high byte write blocks matches
// - value registers read/write, no reset
// - wrap at modulo, restart from zero
// - halt inhibits captures
`timescale 1ns/10ps
`include "tcc_defs.vh"

module tcc_top
(
  // clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // register port
  input  wire [2:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // modulo low byte port
  input  wire [7:0] mod_lo_wdata,
  input  wire       mod_lo_wr,
  // channel pins
  input  wire       chan0_pin_in,
  output reg        chan0_pin_out,
  output reg        chan0_pin_oe,
  input  wire       chan1_pin_in,
  output reg        chan1_pin_out,
  output reg        chan1_pin_oe,
  // interrupt requests
  output reg        chan0_irq,
  output reg        chan1_irq
);

  // ***********************************
  // registers
  // ***********************************
  reg  [7:0]  ctrl0_reg;
  reg  [7:0]  ctrl1_reg;
  reg  [7:0]  tctrl_reg;
  reg  [15:0] count_reg;
  reg  [15:0] mod_reg;
  reg         mod_block_reg;
  reg         sel1_reg;

  wire        buffered = ctrl0_reg[`TCC_BIT_MSB];
  wire        halt     = tctrl_reg[`TCC_BIT_HALT];
  wire        wrap     = !halt && (count_reg == mod_reg) && !mod_block_reg;
  wire        flag0;
  wire        flag1;
  wire [15:0] value0;
  wire [15:0] value1;
  wire        p0_out;
  wire        p0_oe;
  wire        p1_out;
  wire        p1_oe;
  wire [15:0] buf_value = sel1_reg ? value1 : value0;

  wire wr_c0  = reg_wr && (reg_addr == `TCC_OFS_CH0_CTRL);
  wire wr_c1  = reg_wr && (reg_addr == `TCC_OFS_CH1_CTRL) && !buffered;
  wire rd_c0  = reg_rd && (reg_addr == `TCC_OFS_CH0_CTRL);
  wire rd_c1  = reg_rd && (reg_addr == `TCC_OFS_CH1_CTRL);
  wire wr_tc  = reg_wr && (reg_addr == `TCC_OFS_TIMER_CTRL);
  wire wr_mh  = reg_wr && (reg_addr == `TCC_OFS_MOD_HI);

  // ***********************************
  // counter and modulo
  // ***********************************
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      tctrl_reg     <= `TCC_TCTRL_RST;
      count_reg     <= 16'h0000;
      mod_reg       <= `TCC_MOD_RST;
      mod_block_reg <= 1'b0;
      sel1_reg      <= 1'b0;
    end
    else
    begin
      if (wr_tc)
        tctrl_reg <= {reg_wdata[`TCC_BIT_HALT], 7'h00};
      if (wr_tc && reg_wdata[`TCC_BIT_CLEAR])
        count_reg <= 16'h0000;
      else if (wrap)
        count_reg <= 16'h0000;
      else if (!halt)
        count_reg <= count_reg + 16'h0001;
      if (wr_mh)
      begin
        mod_reg[15:8] <= reg_wdata;
        mod_block_reg <= 1'b1;
      end
      if (mod_lo_wr)
      begin
        mod_reg[7:0]  <= mod_lo_wdata;
        mod_block_reg <= 1'b0;
      end
      if (!buffered)
        sel1_reg <= 1'b0;
      else if (wrap)
        sel1_reg <= !sel1_reg;
    end
  end

  // ***********************************
  // control registers
  // ***********************************
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl0_reg <= `TCC_CTRL_RST;
      ctrl1_reg <= `TCC_CTRL_RST;
    end
    else
    begin
      if (wr_c0)
        ctrl0_reg <= {1'b0, reg_wdata[6:0]};
      if (wr_c1)
        ctrl1_reg <= {1'b0, reg_wdata[6], 1'b0, reg_wdata[4:0]};
      else if (buffered)
        ctrl1_reg[`TCC_BIT_IE] <= 1'b0;
    end
  end

  // ***********************************
  // channels
  // ***********************************
  tcc_channel u_chan0
  (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .count      (count_reg),
    .wrap       (wrap),
    .halt       (halt),
    .buffered   (buffered),
    .buf_value  (buf_value),
    .enable     (1'b1),
    .ctrl       (ctrl0_reg),
    .ctrl_rd    (rd_c0),
    .ctrl_wr    (wr_c0),
    .flag_wdata (reg_wdata[`TCC_BIT_FLAG]),
    .hi_rd      (reg_rd && (reg_addr == `TCC_OFS_CH0_HI)),
    .lo_rd      (reg_rd && (reg_addr == `TCC_OFS_CH0_LO)),
    .hi_wr      (reg_wr && (reg_addr == `TCC_OFS_CH0_HI)),
    .lo_wr      (reg_wr && (reg_addr == `TCC_OFS_CH0_LO)),
    .wdata      (reg_wdata),
    .pin_in     (chan0_pin_in),
    .pin_out    (p0_out),
    .pin_oe     (p0_oe),
    .flag       (flag0),
    .value      (value0)
  );

  tcc_channel u_chan1
  (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .count      (count_reg),
    .wrap       (wrap),
    .halt       (halt),
    .buffered   (1'b0),
    .buf_value  (value1),
    .enable     (!buffered),
    .ctrl       (ctrl1_reg),
    .ctrl_rd    (rd_c1),
    .ctrl_wr    (wr_c1),
    .flag_wdata (reg_wdata[`TCC_BIT_FLAG]),
    .hi_rd      (reg_rd && (reg_addr == `TCC_OFS_CH1_HI)),
    .lo_rd      (reg_rd && (reg_addr == `TCC_OFS_CH1_LO)),
    .hi_wr      (reg_wr && (reg_addr == `TCC_OFS_CH1_HI)),
    .lo_wr      (reg_wr && (reg_addr == `TCC_OFS_CH1_LO)),
    .wdata      (reg_wdata),
    .pin_in     (chan1_pin_in),
    .pin_out    (p1_out),
    .pin_oe     (p1_oe),
    .flag       (flag1),
    .value      (value1)
  );

  // ***********************************
  // outputs and read data
  // ***********************************
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      reg_rdata     <= 8'h00;
      chan0_pin_out <= 1'b1;
      chan0_pin_oe  <= 1'b0;
      chan1_pin_out <= 1'b1;
      chan1_pin_oe  <= 1'b0;
      chan0_irq     <= 1'b0;
      chan1_irq     <= 1'b0;
    end
    else
    begin
      chan0_pin_out <= p0_out;
      chan0_pin_oe  <= p0_oe;
      chan1_pin_out <= p1_out;
      chan1_pin_oe  <= p1_oe;
      chan0_irq     <= flag0 && ctrl0_reg[`TCC_BIT_IE];
      chan1_irq     <= flag1 && ctrl1_reg[`TCC_BIT_IE] && !buffered;
      reg_rdata     <= 8'h00;
      if (reg_rd)
      begin
        case (reg_addr)
          `TCC_OFS_CH0_CTRL:   reg_rdata <= {flag0, ctrl0_reg[6:0]};
          `TCC_OFS_CH0_HI:     reg_rdata <= value0[15:8];
          `TCC_OFS_CH0_LO:     reg_rdata <= value0[7:0];
          `TCC_OFS_CH1_CTRL:   reg_rdata <= {flag1, ctrl1_reg[6:0]};
          `TCC_OFS_CH1_HI:     reg_rdata <= value1[15:8];
          `TCC_OFS_CH1_LO:     reg_rdata <= value1[7:0];
          `TCC_OFS_TIMER_CTRL: reg_rdata <= tctrl_reg;
          `TCC_OFS_MOD_HI:     reg_rdata <= mod_reg[15:8];
          default:             reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule // tcc_top

// *** sim/tcc_pin_model.sv ***
// far-side pin drivers for both channels
// assumes pins are sampled on clk; design drive wins while oe is high
`timescale 1ns/10ps

module tcc_pin_model
(
  // clock
  input  wire       clk,
  // design side of the pins
  input  wire [1:0] pin_out,
  input  wire [1:0] pin_oe,
  output wire [1:0] pin_in
);
  reg [1:0] ext_reg;

  initial ext_reg = 2'b00;

  // wire level: the design's drive, else the external driver
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_reg);

  task drive(input integer ch, input reg v);
    begin
      @(posedge clk);
      ext_reg[ch] <= v;
    end
  endtask
endmodule // tcc_pin_model

// *** sim/tcc_props.sv ***
// assertions on the ports of the capture/compare unit
// assumes it is bound to tcc_top
`timescale 1ns/10ps

module tcc_props
(
  // clock and reset
  input wire       clk,
  input wire       sys_rst,
  // register port
  input wire [2:0] reg_addr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  // pins and requests
  input wire       chan0_pin_out,
  input wire       chan0_pin_oe,
  input wire       chan1_pin_oe,
  input wire       chan0_irq,
  input wire       chan1_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  irq_reset_a: assert property ($fell(sys_rst) |-> !chan0_irq && !chan1_irq)
    else $error("irq high after reset");
  oe_reset_a: assert property ($fell(sys_rst) |-> !chan0_pin_oe && !chan1_pin_oe)
    else $error("pin driven after reset");
  irq_flag_a: assert property (reg_rd && reg_addr == 3'h0 |=>
    chan0_irq == (reg_rdata[7] && reg_rdata[6])) else $error("irq not flag and enable");
  buf_off_a: assert property (reg_rd && reg_addr == 3'h0 ##1 reg_rdata[5]
    |=> !chan1_pin_oe && !chan1_irq) else $error("channel one active in buffered mode");
  pin_free_a: assert property (reg_rd && reg_addr == 3'h0 ##1 reg_rdata[3:2] == 2'b00
    |=> !chan0_pin_oe) else $error("pin driven with edge field zero");
  preset_lvl_a: assert property (reg_rd && reg_addr == 3'h0 ##1 reg_rdata[3:2] == 2'b00
    |=> chan0_pin_out == !$past(reg_rdata[4])) else $error("preset level wrong");
  capture_oe_a: assert property (reg_rd && reg_addr == 3'h0 ##1
    (reg_rdata[5:4] == 2'b00 && reg_rdata[3:2] != 2'b00) |=> !chan0_pin_oe)
    else $error("pin driven in capture mode");
  compare_oe_a: assert property (reg_rd && reg_addr == 3'h0 ##1
    (reg_rdata[4] && reg_rdata[3:2] != 2'b00) |=> chan0_pin_oe)
    else $error("pin not driven in compare mode");
endmodule // tcc_props

bind tcc_top tcc_props chk_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan0_pin_out(chan0_pin_out),
  .chan0_pin_oe(chan0_pin_oe), .chan1_pin_oe(chan1_pin_oe), .chan0_irq(chan0_irq),
  .chan1_irq(chan1_irq));

// *** sim/test_tcc_top.sv ***
// self-checking bench for the capture/compare unit
// assumes tcc_top, tcc_pin_model and the bound checker
`timescale 1ns/10ps

module test_tcc_top;
  reg        clk;
  reg        sys_rst;
  reg  [2:0] reg_addr;
  reg  [7:0] reg_wdata;
  reg        reg_wr;
  reg        reg_rd;
  reg  [7:0] mod_lo_wdata;
  reg        mod_lo_wr;
  wire [7:0] reg_rdata;
  wire [1:0] pin_in;
  wire [1:0] pin_out;
  wire [1:0] pin_oe;
  wire [1:0] irq;
  integer    error_cnt;
  integer    n_compared;
  integer    seed;
  integer    i;
  integer    k;
  reg  [7:0] d;
  reg  [7:0] m;
  reg        p;

  tcc_top dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mod_lo_wdata(mod_lo_wdata),
    .mod_lo_wr(mod_lo_wr), .chan0_pin_in(pin_in[0]), .chan0_pin_out(pin_out[0]),
    .chan0_pin_oe(pin_oe[0]), .chan1_pin_in(pin_in[1]), .chan1_pin_out(pin_out[1]),
    .chan1_pin_oe(pin_oe[1]), .chan0_irq(irq[0]), .chan1_irq(irq[1]));
  tcc_pin_model pin_u (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

  always #10 clk = ~clk;

  task close_out;
    begin
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  task chk(input [8*8-1:0] nm, input [7:0] e, input [7:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
      end
    end
  endtask

  task wr(input [2:0] a, input [7:0] v);
    begin
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask

  task rd(input [2:0] a, output [7:0] v);
    begin
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
    end
  endtask

  initial
  begin
    #400000;
    error_cnt = error_cnt + 1;
    close_out;
  end

  initial
  begin
    clk = 0; sys_rst = 1; reg_addr = 0; reg_wdata = 0; reg_wr = 0; reg_rd = 0;
    mod_lo_wdata = 0; mod_lo_wr = 0; error_cnt = 0; n_compared = 0; seed = 32'h62b4815c;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    // ****************************
    // reset values
    // ****************************
    rd(3'h0, d); chk("ctrl0", 8'h00, d);
    rd(3'h3, d); chk("ctrl1", 8'h00, d);
    // ****************************
    // compare toggle on channel 0
    // ****************************
    wr(3'h6, 8'hc0);
    wr(3'h7, 8'h00);
    @(posedge clk) mod_lo_wr <= 1'b1; mod_lo_wdata <= 8'h20;
    @(posedge clk) mod_lo_wr <= 1'b0;
    k = 4 + ({$random(seed)} % 16);
    wr(3'h1, 8'h00);
    wr(3'h2, k[7:0]);
    wr(3'h0, 8'h54);
    wr(3'h6, 8'h00);
    #1 p = pin_out[0];
    i = 0;
    while (irq[0] !== 1'b1 && i < 100)
    begin
      @(posedge clk); #1 i = i + 1;
    end
    chk("match_at", 8'h01, {7'h0, (i == k + 2)});
    chk("toggle", {7'h0, ~p}, pin_out[0]);
    // ****************************
    // flag clearing
    // ****************************
    wr(3'h6, 8'h80);
    wr(3'h0, 8'h54);
    wr(3'h0, 8'hd4);
    rd(3'h0, d); chk("armed", 8'hd4, d);
    wr(3'h0, 8'h54);
    rd(3'h0, d); chk("cleared", 8'h54, d);
    chk("irq0", 0, irq[0]);
    // ****************************
    // capture edges on channel 1
    // ****************************
    wr(3'h3, 8'h04);
    pin_u.drive(1, 1'b1);
    pin_u.drive(1, 1'b0);
    repeat (3) @(posedge clk);
    rd(3'h3, d); chk("halted", 8'h04, d);
    wr(3'h6, 8'h00);
    for (i = 1; i < 4; i = i + 1)
    begin
      m = {4'h0, i[1:0], 2'b00};
      wr(3'h3, m); rd(3'h3, d); wr(3'h3, m);
      pin_u.drive(1, 1'b1); repeat (3) @(posedge clk);
      rd(3'h3, d); wr(3'h3, m); chk("rise", {7'h0, i[0]}, d[7]);
      pin_u.drive(1, 1'b0); repeat (3) @(posedge clk);
      rd(3'h3, d); wr(3'h3, m); chk("fall", {7'h0, i[1]}, d[7]);
    end
    // ****************************
    // captured count and high byte latch
    // ****************************
    wr(3'h6, 8'hc0);
    wr(3'h6, 8'h00);
    pin_u.drive(1, 1'b1); repeat (3) @(posedge clk);
    rd(3'h3, d); chk("cap_flg", 8'h8c, d);
    wr(3'h3, 8'h0c);
    rd(3'h4, d); chk("cap_hi", 8'h00, d);
    pin_u.drive(1, 1'b0); repeat (3) @(posedge clk);
    rd(3'h3, d); chk("cap_blk", 8'h0c, d);
    rd(3'h5, d); chk("cap_lo", 8'h01, d);
    pin_u.drive(1, 1'b1); repeat (3) @(posedge clk);
    rd(3'h3, d); chk("cap_go", 8'h8c, d);
    // ****************************
    // buffered mode and preset levels
    // ****************************
    wr(3'h0, 8'h24);
    wr(3'h3, 8'h54);
    repeat (4) @(posedge clk);
    rd(3'h0, d); chk("buf", 8'h24, d & 8'h7f);
    repeat (2) @(posedge clk);
    #1 chk("oe1", 0, pin_oe[1]);
    rd(3'h3, d); chk("ch1_lock", 8'h8c, d);
    for (i = 0; i < 2; i = i + 1)
    begin
      wr(3'h0, {3'h0, i[0], 4'h0});
      repeat (2) @(posedge clk);
      rd(3'h0, d); chk("preset", {7'h0, ~i[0]}, pin_out[0]);
    end
    wr(3'h0, 8'h04);
    repeat (2) @(posedge clk);
    rd(3'h0, d); chk("cap_oe", 0, pin_oe[0]);
    // ****************************
    // toggle on wrap, full duty, compare latch
    // ****************************
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h20);
    wr(3'h0, 8'h1a);
    repeat (3) @(posedge clk);
    #1 p = pin_out[0];
    repeat (33) @(posedge clk);
    #1 chk("tov", {7'h0, ~p}, pin_out[0]);
    wr(3'h0, 8'h1b);
    repeat (75) @(posedge clk);
    #1 chk("max_a", 8'h01, pin_out[0]);
    repeat (33) @(posedge clk);
    #1 chk("max_b", 8'h01, pin_out[0]);
    wr(3'h1, 8'h00);
    rd(3'h0, d);
    wr(3'h0, 8'h1a);
    repeat (40) @(posedge clk);
    rd(3'h0, d); chk("cmp_blk", 8'h1a, d);
    wr(3'h2, 8'h20);
    repeat (40) @(posedge clk);
    rd(3'h0, d); chk("cmp_go", 8'h9a, d);
    close_out;
  end
endmodule // test_tcc_top
